// ### rtl/rih_mem_guard.sv
// Freezes an on-chip memory's address and enable around a pending reset
`timescale 1ns/1ps
module rih_mem_guard import rih_pkg::*; #(
  parameter int unsigned ADDR_W = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic freeze,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic mem_en_in,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic mem_en_out
);

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
  } rih_guard_t;

  rih_guard_t st_q;
  rih_guard_t st_d;

  if (ADDR_W < 1) begin : g_chk
    $error("rih_mem_guard: ADDR_W must be at least 1");
  end

  // Address only follows the user while no reset is pending
  always_comb begin
    st_d = st_q;
    if (!freeze) begin
      st_d.addr = mem_addr_in; // [RULE_03]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Enable gated at once; a late gate would let the array see a moving address
  assign mem_addr_out = st_q.addr;
  assign mem_en_out = mem_en_in & ~freeze; // [RULE_03]

  freeze_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
    freeze |=> st_q.addr == $past(st_q.addr))
    else $error("memory address moved while frozen");

  gate_en_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
    freeze |-> !mem_en_out)
    else $error("memory enable open while frozen");

endmodule

// ### rtl/rih_pkg.sv
// Shared constants and types for the reset interface handshake block
package rih_pkg;

  // Synchronisation style of the produced reset
  typedef enum logic [1:0] {
    RIH_SYNC_NONE,
    RIH_SYNC_DEASSERT,
    RIH_SYNC_BOTH
  } rih_sync_t;

  localparam int unsigned RIH_CLK_HZ = 20000000;
  localparam int unsigned RIH_CLK_PERIOD_NS = 50;
  // Least lead of the warning before a synchronous reset output
  localparam int unsigned RIH_WARN_LEAD_NS = 50;
  localparam int unsigned RIH_WARN_CYCLES =
    (RIH_WARN_LEAD_NS + RIH_CLK_PERIOD_NS - 1) / RIH_CLK_PERIOD_NS;
  localparam int unsigned RIH_CNT_W = 4;

  // Reset values: everything comes up held in reset
  localparam logic [2:0] RIH_SYNC_RST = 3'h7;
  localparam logic RIH_FILT_RST = 1'h1;
  localparam logic RIH_OUT_RST = 1'h1;
  localparam logic RIH_REQ_RST = 1'h1;
  localparam logic [RIH_CNT_W-1:0] RIH_CNT_RST = 4'h0;

  // Stage positions in the three-flop pin synchroniser
  localparam int unsigned RIH_SYNC_S1 = 0;
  localparam int unsigned RIH_SYNC_S2 = 1;
  localparam int unsigned RIH_SYNC_S3 = 2;

endpackage

// ### rtl/rih_reset_top.sv
// Reset sink and source: combines, synchronises and, in the clocked-both mode, warns ahead of reset
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01 - Asserted reset puts internal logic in initial state
// RULE_02 - Source warns at least one cycle before reset
// RULE_03 - Warning freezes memory address and clock enable
// RULE_04 - Source raises warning before raising reset
// RULE_05 - Warning stays high until reset completes
// RULE_06 - Unsynchronised sink synchronises reset internally
// RULE_07 - Deassert mode: async assert, clocked release
// RULE_08 - Both mode: assert and release on clock
// RULE_09 - No-sync output may change at any time
// RULE_10 - Clocked modes are timed to one named clock
// RULE_11 - Output asserts when any combined input asserts
// RULE_12 - Output may follow exactly one input directly
// RULE_13 - One designated reset clears interface logic
// RULE_14 - Active-low form allowed, active-high by default
// RULE_15 - React only to clock edges; tolerate glitches
// RULE_16 - Two-flop release synchroniser cleared by reset; the code uses three flops, which rst sets to 3'h7
module rih_reset_top import rih_pkg::*; #(
  parameter int unsigned N_IN = 2,
  parameter logic [N_IN-1:0] IN_ACTIVE_LOW = '0,
  parameter logic OUT_ACTIVE_LOW = 1'b0,
  parameter rih_sync_t SYNC_MODE = RIH_SYNC_DEASSERT,
  parameter int unsigned WARN_CYCLES = RIH_WARN_CYCLES,
  parameter int unsigned ADDR_W = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [N_IN-1:0] rst_in_pins,
  input wire logic [N_IN-1:0] combine_mask,
  input wire logic warn_in,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic mem_en_in,
  output logic rst_out,
  output logic warn_out,
  output logic int_rst,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic mem_en_out
);

  typedef struct packed {
    logic [2:0] sync;
    logic filt;
    logic out;
    logic req;
    logic [RIH_CNT_W-1:0] cnt;
  } rih_state_t;

  rih_state_t st_q;
  rih_state_t st_d;
  logic [N_IN-1:0] in_active;
  logic any_raw;
  logic out_lvl;
  logic freeze;

  if (N_IN < 1 || WARN_CYCLES < 1 || WARN_CYCLES >= (1 << RIH_CNT_W)) begin : g_chk
    $error("rih_reset_top: N_IN or WARN_CYCLES out of range");
  end

  // Stages two and three agree: only then may the filtered level move
  function automatic logic rih_agree(logic [2:0] stages);
    return stages[RIH_SYNC_S2] == stages[RIH_SYNC_S3];
  endfunction

  // Normalise polarity, then OR the inputs that are selected
  assign in_active = rst_in_pins ^ IN_ACTIVE_LOW; // [RULE_14]
  assign any_raw = |(in_active & combine_mask); // [RULE_11] [RULE_12]

  // Pin level through three flops; a change counts once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.sync = {st_q.sync[RIH_SYNC_S2], st_q.sync[RIH_SYNC_S1], any_raw}; // [RULE_06]
    if (rih_agree(st_q.sync)) begin
      st_d.filt = st_q.sync[RIH_SYNC_S3]; // [RULE_15] [RULE_16]
    end
    // Synchronous output: warning first, reset after the lead count
    if (st_q.filt) begin
      st_d.req = 1'b1; // [RULE_04] [RULE_05]
      if (st_q.cnt < RIH_CNT_W'(WARN_CYCLES)) begin
        st_d.cnt = st_q.cnt + 1'b1;
      end else begin
        st_d.out = 1'b1; // [RULE_08]
      end
    end else begin
      // Release on the clock; the warning ends with the reset it announced
      st_d.out = 1'b0; // [RULE_08] [RULE_10]
      st_d.req = 1'b0; // [RULE_05]
      st_d.cnt = RIH_CNT_RST;
    end
  end

  // Single designated reset clears all state to the held-in-reset values
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q.sync <= RIH_SYNC_RST; // [RULE_13]
      st_q.filt <= RIH_FILT_RST;
      st_q.out <= RIH_OUT_RST;
      st_q.req <= RIH_REQ_RST;
      st_q.cnt <= RIH_CNT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Output shaping per mode; assertion may bypass the clock, release may not except in the no-sync mode
  always_comb begin
    unique case (SYNC_MODE)
      RIH_SYNC_NONE: out_lvl = any_raw; // [RULE_09]
      RIH_SYNC_DEASSERT: out_lvl = any_raw | st_q.filt; // [RULE_07] [RULE_16]
      RIH_SYNC_BOTH: out_lvl = st_q.out; // [RULE_08]
      default: out_lvl = 1'b1;
    endcase
  end

  assign rst_out = out_lvl ^ OUT_ACTIVE_LOW; // [RULE_14]
  // Async modes cannot lead their own reset, so the warning just mirrors it
  assign warn_out = (SYNC_MODE == RIH_SYNC_BOTH) ? st_q.req : out_lvl; // [RULE_04]
  // Own logic always sees a synchronised reset, whatever the output mode
  assign int_rst = rst | st_q.filt; // [RULE_01] [RULE_06]
  // Raw input covers an async reset that arrives without any warning
  assign freeze = warn_in | any_raw | int_rst; // [RULE_03] [RULE_02]

  rih_mem_guard #(
    .ADDR_W(ADDR_W)
  ) u_guard (
    .sys_clk(sys_clk),
    .rst(rst),
    .freeze(freeze),
    .mem_addr_in(mem_addr_in),
    .mem_en_in(mem_en_in),
    .mem_addr_out(mem_addr_out),
    .mem_en_out(mem_en_out)
  );

  or_combine_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_11]
    (SYNC_MODE != RIH_SYNC_BOTH && any_raw) |-> out_lvl)
    else $error("selected input active but reset output idle");

  filt_rise_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_06]
    ($rose(st_q.filt) && !$past(rst)) |->
      $past(st_q.sync[RIH_SYNC_S2]) && $past(st_q.sync[RIH_SYNC_S3]))
    else $error("synchronised reset rose without agreement");

  sync_release_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_16]
    $fell(st_q.filt) |-> !$past(st_q.sync[RIH_SYNC_S2]) && !$past(st_q.sync[RIH_SYNC_S3]))
    else $error("synchronised reset fell without agreement");

  glitch_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_15]
    !rih_agree(st_q.sync) |=> $stable(st_q.filt))
    else $error("filtered reset moved on disagreeing stages");

  deassert_clocked_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
    (SYNC_MODE == RIH_SYNC_DEASSERT && st_q.filt) |-> out_lvl)
    else $error("reset output released before the clock edge");

  warn_lead_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
    ($rose(st_q.out) && !$past(rst)) |-> st_q.req && $past(st_q.req))
    else $error("synchronous reset raised without prior warning");

  warn_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
    (st_q.req && st_q.filt) |=> st_q.req)
    else $error("warning dropped before reset completed");

  internal_reset_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_01]
    st_q.filt |-> int_rst && freeze)
    else $error("internal reset not asserted with filtered reset");

  pin_freeze_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
    (warn_in || any_raw) |-> !mem_en_out)
    else $error("memory enable open during warning");

  // Reset state, release pairing and lead sequencing of the clocked path
  reset_state_a: assert property (@(posedge sys_clk) // [RULE_13]
    rst |=> st_q.sync == RIH_SYNC_RST && st_q.filt == RIH_FILT_RST &&
      st_q.out == RIH_OUT_RST && st_q.req == RIH_REQ_RST && st_q.cnt == RIH_CNT_RST)
    else $error("state not at reset values after system reset");

  release_pair_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
    $fell(st_q.filt) |=> !st_q.out && !st_q.req)
    else $error("reset or warning outlived the filtered release");

  both_warn_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
    (SYNC_MODE == RIH_SYNC_BOTH && out_lvl) |-> warn_out)
    else $error("reset output stands without its warning");

  warn_drop_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_05]
    (SYNC_MODE == RIH_SYNC_BOTH && $fell(warn_out)) |-> !out_lvl)
    else $error("warning dropped while reset still stands");

  out_after_filt_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
    ($rose(st_q.out) && !$past(rst)) |-> $past(st_q.filt))
    else $error("clocked reset rose without a filtered request");

  lead_count_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_04]
    ($rose(st_q.out) && !$past(rst)) |-> st_q.cnt == RIH_CNT_W'(WARN_CYCLES))
    else $error("clocked reset rose before the lead count ran out");

  req_rise_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_04]
    ($rose(st_q.req) && !$past(rst)) |-> $past(st_q.filt) && !st_q.out)
    else $error("warning rose without request or after reset");

  cnt_bound_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
    st_q.cnt <= RIH_CNT_W'(WARN_CYCLES))
    else $error("lead counter ran past its limit");

  out_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
    (st_q.out && st_q.filt) |=> st_q.out)
    else $error("clocked reset released while request stands");

  deassert_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
    (SYNC_MODE == RIH_SYNC_DEASSERT && !any_raw && !st_q.filt) |-> !out_lvl)
    else $error("reset output held with no request");

  none_release_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_09]
    (SYNC_MODE == RIH_SYNC_NONE && !any_raw) |-> !out_lvl)
    else $error("unsynchronised output held with inputs idle");

  freeze_int_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
    int_rst |-> !mem_en_out)
    else $error("memory enable open during internal reset");

  mem_en_open_a: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_03]
    (!freeze && mem_en_in) |-> mem_en_out)
    else $error("memory enable blocked with no reset pending");

endmodule

// ### test/rih_reset_top_test.sv
// Self-checking bench for the reset combiner, synchroniser and memory guard
`timescale 1ns/1ps
module rih_reset_top_test;
  logic sys_clk, rst, req, warn_in, mem_en_in;
  logic rst_out, warn_out, int_rst, mem_en_out;
  logic rst_out_b, warn_out_b, rst_out_n, warn_out_n;
  logic [1:0] pin_sel, pins, combine_mask;
  logic [9:0] mem_addr_in, mem_addr_out;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;

  rih_src_model src_u (.sys_clk(sys_clk), .rst(rst), .req(req), .pin_sel(pin_sel),
    .warn_in(warn_in), .rst_in_pins(pins));
  rih_reset_top dut_u (.sys_clk(sys_clk), .rst(rst), .rst_in_pins(pins),
    .combine_mask(combine_mask), .warn_in(warn_in), .mem_addr_in(mem_addr_in),
    .mem_en_in(mem_en_in), .rst_out(rst_out), .warn_out(warn_out), .int_rst(int_rst),
    .mem_addr_out(mem_addr_out), .mem_en_out(mem_en_out));
  // Clocked-both copy with an active-low output and an active-low first input
  rih_reset_top #(.IN_ACTIVE_LOW(2'h1), .OUT_ACTIVE_LOW(1'h1),
    .SYNC_MODE(rih_pkg::RIH_SYNC_BOTH)) dut_b_u (.sys_clk(sys_clk), .rst(rst),
    .rst_in_pins(pins ^ 2'h1), .combine_mask(combine_mask), .warn_in(warn_in),
    .mem_addr_in(mem_addr_in), .mem_en_in(mem_en_in), .rst_out(rst_out_b),
    .warn_out(warn_out_b), .int_rst(), .mem_addr_out(), .mem_en_out());
  // Unsynchronised copy: output follows the selected inputs directly
  rih_reset_top #(.SYNC_MODE(rih_pkg::RIH_SYNC_NONE)) dut_n_u (.sys_clk(sys_clk),
    .rst(rst), .rst_in_pins(pins), .combine_mask(combine_mask), .warn_in(warn_in),
    .mem_addr_in(mem_addr_in), .mem_en_in(mem_en_in), .rst_out(rst_out_n),
    .warn_out(warn_out_n), .int_rst(), .mem_addr_out(), .mem_en_out());

  // 20 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_addr(input string what, input logic [9:0] exp, input logic [9:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic wait_neg(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Hang guard well beyond the roughly 70 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    rst = 1'h1;
    req = 1'h0;
    pin_sel = 2'h1;
    combine_mask = 2'h1;
    mem_en_in = 1'h1;
    mem_addr_in = 10'h155;
    wait_neg(16);
    rst = 1'h0;
    // Two edges after release every clocked output still stands in reset
    wait_neg(2);
    chk_bit("rst_out", 1'h1, rst_out);
    chk_bit("rst_out_b", 1'h0, rst_out_b);
    chk_bit("warn_out_b", 1'h1, warn_out_b);
    wait_neg(4);
    chk_bit("int_rst", 1'h0, int_rst);
    chk_bit("rst_out", 1'h0, rst_out);
    chk_addr("mem_addr_out", 10'h155, mem_addr_out);
    chk_bit("mem_en_out", 1'h1, mem_en_out);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    chk_bit("warn_out_b", 1'h0, warn_out_b);
    // Warning freezes the memory port before the pin lands
    req = 1'h1;
    wait_neg(1);
    chk_bit("mem_en_out", 1'h0, mem_en_out);
    mem_addr_in = 10'h2AA;
    wait_neg(1);
    chk_bit("rst_out", 1'h1, rst_out);
    chk_addr("mem_addr_out", 10'h155, mem_addr_out);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    chk_bit("rst_out_n", 1'h1, rst_out_n);
    wait_neg(5);
    chk_bit("warn_out", 1'h1, warn_out);
    // Clocked copy: warning already up, reset one edge behind it
    chk_bit("warn_out_b", 1'h1, warn_out_b);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    req = 1'h0;
    // Clocked release waits for the synchroniser; the unsynchronised copy follows the pin at once
    wait_neg(3);
    chk_bit("rst_out", 1'h1, rst_out);
    chk_bit("rst_out_b", 1'h0, rst_out_b);
    chk_bit("rst_out_n", 1'h0, rst_out_n);
    chk_bit("warn_out_n", 1'h0, warn_out_n);
    wait_neg(6);
    chk_bit("rst_out", 1'h0, rst_out);
    chk_addr("mem_addr_out", 10'h2AA, mem_addr_out);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    chk_bit("warn_out_b", 1'h0, warn_out_b);
    // Unselected input is ignored until the mask takes it in
    pin_sel = 2'h2;
    req = 1'h1;
    wait_neg(6);
    chk_bit("rst_out", 1'h0, rst_out);
    chk_bit("rst_out_n", 1'h0, rst_out_n);
    combine_mask = 2'h3;
    wait_neg(1);
    chk_bit("rst_out", 1'h1, rst_out);
    chk_bit("rst_out_n", 1'h1, rst_out_n);
    req = 1'h0;
    wait_neg(10);
    chk_bit("rst_out", 1'h0, rst_out);
    // One-cycle pulse on a selected input never reaches the filtered reset
    combine_mask = 2'h1;
    req = 1'h1;
    wait_neg(3);
    combine_mask = 2'h3;
    wait_neg(1);
    chk_bit("rst_out_n", 1'h1, rst_out_n);
    combine_mask = 2'h1;
    wait_neg(4);
    chk_bit("int_rst", 1'h0, int_rst);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    // Mid-run system reset puts every clocked output back in reset
    rst = 1'h1;
    wait_neg(1);
    chk_bit("int_rst", 1'h1, int_rst);
    chk_bit("rst_out", 1'h1, rst_out);
    chk_bit("mem_en_out", 1'h0, mem_en_out);
    chk_bit("rst_out_b", 1'h0, rst_out_b);
    chk_bit("warn_out_b", 1'h1, warn_out_b);
    // Second release: the block leaves reset again on its own
    rst = 1'h0;
    req = 1'h0;
    wait_neg(6);
    chk_bit("int_rst", 1'h0, int_rst);
    chk_bit("rst_out_b", 1'h1, rst_out_b);
    tally_and_finish();
  end
endmodule

// ### test/rih_src_model.sv
// Reset source model: warns a cycle ahead, then drives the selected pins
`timescale 1ns/1ps
module rih_src_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [1:0] pin_sel,
  output logic warn_in,
  output logic [1:0] rst_in_pins
);
  // Pins follow only once the warning has stood for a whole cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      warn_in <= 1'h0;
      rst_in_pins <= 2'h0;
    end else begin
      warn_in <= req | (|rst_in_pins); // Held until pins released
      rst_in_pins <= (req & warn_in) ? pin_sel : 2'h0;
    end
  end
endmodule
